// ==== bench/client_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module client_model (
    input wire logic clk,
    input wire logic rst,
    input wire lldma_pkg::client_out_t client_out,
    output lldma_pkg::client_in_t client_in,
    input wire logic req_en,
    input wire logic [7:0] term_n,
    output logic [7:0] cmd,
    output logic eob_seen
);
    import lldma_pkg::*;
    logic [7:0] cnt;
    logic stat_done;
    logic cut;
    logic term;
    // after a fatal terminate the request stays low until re-armed
    assign cut = (term_n != 8'h00) && (cnt >= term_n);
    assign term = (term_n != 8'h00) && !stat_done && (cnt + 8'h01 >= term_n);
    // lines not acknowledged carry the inverse, or status 15 on store-status, never a stale byte
    assign client_in = '{data_req: req_en && !cut, terminate: term,
        wdata: client_out.store_status ? 8'h15 :
        (client_out.data_ack ? cnt : ~cnt)};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 8'h00;
            cmd <= 8'h00;
            eob_seen <= 1'b0;
            stat_done <= 1'b0;
        end else begin
            if (client_out.data_ack)
                cnt <= cnt + 8'h01;
            if (client_out.data_ack && client_out.end_of_buffer_line)
                eob_seen <= 1'b1;
            if (client_out.store_status)
                stat_done <= 1'b1;
            if (client_out.type_fetch && (client_out.rdata[7:6] == 2'h1 ||
                client_out.rdata[7:6] == 2'h2))
                cmd <= client_out.rdata;
        end
    end
endmodule
`default_nettype wire

// ==== bench/linked_list_dma_channel_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lldma_defines.svh"
module linked_list_dma_channel_tb;
    import lldma_pkg::*;
    typedef struct packed {
        logic [7:0] ts;
        logic [7:0] len;
        logic [7:0] term_n;
        logic [7:0] ctrl;
        logic [7:0] nbytes;
        logic [7:0] exp_ts;
        logic [7:0] exp_cmd;
        logic [1:0] eob_irq;
    } row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    client_in_t client_in;
    client_out_t client_out;
    mem_out_t mem_out;
    logic bus_gnt = 1'b0;
    logic mem_ready = 1'b0;
    logic [15:0] mem_rdata;
    logic irq_req;
    logic req_en = 1'b0;
    logic [7:0] term_n = 8'h00;
    logic [7:0] cmd;
    logic eob_seen;
    logic [7:0] mem [0:511];
    logic [31:0] q;
    row_t r;
    int n_errors = 0;
    int comparisons = 0;
    row_t rows [6] = '{
        '{8'h02, 8'h03, 8'h00, 8'h03, 8'h03, 8'h05, 8'h00, 2'h0},
        '{8'h03, 8'h02, 8'h00, 8'h0B, 8'h02, 8'h05, 8'h00, 2'h3},
        '{8'h41, 8'h02, 8'h00, 8'h01, 8'h02, 8'h05, 8'h41, 2'h0},
        '{8'h81, 8'h01, 8'h00, 8'h03, 8'h01, 8'h05, 8'h81, 2'h2},
        '{8'h02, 8'h04, 8'h02, 8'h0B, 8'h02, 8'hD5, 8'h00, 2'h1},
        '{8'h05, 8'h01, 8'h00, 8'h05, 8'h00, 8'h05, 8'h00, 2'h1}};
    always #10 clk = ~clk;
    linked_list_dma_channel i_dut (.clk(clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(4'hF),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .scan_sel(1'b1),
        .client_in(client_in), .client_out(client_out), .mem_out(mem_out),
        .bus_gnt(bus_gnt), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
        .irq_req(irq_req));
    client_model i_client (.clk(clk), .rst(rst), .client_out(client_out),
        .client_in(client_in), .req_en(req_en), .term_n(term_n),
        .cmd(cmd), .eob_seen(eob_seen));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // memory answers one cycle after the strobe; idle data is inverted
    // a byte access shows its byte on both lanes
    assign mem_rdata = !mem_ready ? ~{mem[mem_out.addr[8:0]], 8'h00} :
        mem_out.word ? {mem[mem_out.addr[8:0] + 9'h1],
        mem[mem_out.addr[8:0]]} :
        {mem[mem_out.addr[8:0]], mem[mem_out.addr[8:0]]};
    always @(posedge clk) begin
        bus_gnt <= mem_out.bus_req;
        mem_ready <= (mem_out.rd || mem_out.wr) && !mem_ready;
        if (mem_ready && mem_out.addr[8])
            check({mem_out.word, mem_out.rd}, 32'h0);
        else if (mem_ready)
            check(mem_out.word, 32'h1);
        if (mem_ready && mem_out.wr) begin
            mem[mem_out.addr[8:0]] <= mem_out.wdata[7:0];
            if (mem_out.word)
                mem[mem_out.addr[8:0] + 9'h1] <= mem_out.wdata[15:8];
        end
    end
    task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        logic done;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        // waitrequest and read data are settled mid-cycle and hold to the
        // next rising edge, where the access completes
        for (i = 0; i < 100; i++) begin
            @(negedge clk);
            done = (avs_waitrequest === 1'b0);
            q = avs_readdata;
            @(posedge clk);
            if (done)
                break;
        end
        if (i == 100)
            check(32'h1, 32'h0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic put_entry(input int b, input logic [15:0] a,
        input logic [7:0] ts, input logic [7:0] len);
        for (int i = 0; i < 8; i++)
            mem[b + i] = 8'h00;
        mem[b] = a[7:0];
        mem[b + 1] = a[15:8];
        mem[b + 4] = ts;
        mem[b + 6] = len;
    endtask
    task automatic reset_dut();
        rst <= 1'b1;
        req_en <= 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 512; i++)
            mem[i] = 8'hFF;
    endtask
    task automatic wait_stop();
        for (int i = 0; i < 300; i++) begin
            avs(1'b0, `OFF_CTRL_STAT, 32'h0);
            if (q[`CS_RUN] === 1'b0)
                break;
        end
        check(q[`CS_RUN], 32'h0);
    endtask
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        foreach (rows[k]) begin
            r = rows[k];
            reset_dut();
            avs(1'b0, `OFF_CTRL_STAT, 32'h0);
            check(q[7:0], `CS_RESET);
            put_entry(32'h40, 16'h0100, r.ts, r.len);
            put_entry(32'h48, 16'h0000, `TS_END, 8'h00);
            term_n <= r.term_n;
            req_en <= 1'b1;
            avs(1'b1, `OFF_CTRL_STAT, r.ctrl);
            avs(1'b1, `OFF_LIST_PTR, 32'h47);
            wait_stop();
            check(mem[9'h44], r.exp_ts);
            check({mem[9'h47], mem[9'h46]}, r.len -
                (r.term_n != 8'h00 ? r.nbytes : 8'h00));
            check(mem[9'h100 + r.nbytes], 8'hFF);
            if (r.nbytes != 8'h00)
                check(mem[9'h0FF + r.nbytes], r.nbytes - 8'h01);
            check(cmd, r.exp_cmd);
            check({eob_seen, irq_req}, r.eob_irq);
            avs(1'b0, `OFF_LIST_PTR, 32'h0);
            check(q[23:0], r.nbytes != 8'h00 ? 32'h4C : 32'h44);
        end
        reset_dut();
        put_entry(32'h40, 16'h0080, `TS_LINK, 8'h00);
        put_entry(32'h80, 16'h0100, `TS_READY, 8'h01);
        put_entry(32'h88, 16'h0000, `TS_END, 8'h00);
        term_n <= 8'h00;
        avs(1'b1, `OFF_CTRL_STAT, 32'h03);
        avs(1'b1, `OFF_LIST_PTR, 32'h40);
        // the client stays silent for a while, so the bus must be freed
        repeat (40) @(posedge clk);
        check(mem_out.bus_req, 32'h0);
        req_en <= 1'b1;
        wait_stop();
        check(mem[9'h84], `TS_DONE);
        check(mem[9'h100], 8'h00);
        avs(1'b0, `OFF_LIST_PTR, 32'h0);
        check(q[23:0], 32'h8C);
        end_of_test();
    end
endmodule
`default_nettype wire

// ==== rtl/linked_list_dma_channel.sv ====
// Function
// (RULE_01) pointer MS byte write starts channel
// (RULE_02) entries are eight aligned bytes
// (RULE_03) decode type/status codes into entry kinds
// (RULE_04) stop codes clear run, optional interrupt
// (RULE_05) link entry reloads pointer, fetches again
// (RULE_06) pulse type fetch on each type read
// (RULE_07) ready entry: write 04, load address, length
// (RULE_08) no request: release bus, wait client
// (RULE_09) transfer: acknowledge, buffer address, direction
// (RULE_10) end-of-buffer on final byte if notify
// (RULE_11) client supplies or takes byte on acknowledge
// (RULE_12) each byte: address up, count down
// (RULE_13) burst continues only while request held
// (RULE_14) count zero: write 05, next entry
// (RULE_15) completion sets pending per buffer select
// (RULE_16) terminate writes remaining count to length
// (RULE_17) then status code with store-status
// (RULE_18) client status forms low six bits
// (RULE_19) advance pointer, interrupt unless select none
// (RULE_20) client holds request low after fatal terminate
// (RULE_21) data bytes, list accesses sixteen bit
// (RULE_22) handshake lines driven only when scanned
// (RULE_23) pointer low bits ignored, read as 100
// (RULE_24) scanner serves lowest channel first
`timescale 1ns/1ps
`default_nettype none
`include "lldma_defines.svh"
module linked_list_dma_channel (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic scan_sel,
    input wire lldma_pkg::client_in_t client_in,
    output lldma_pkg::client_out_t client_out,
    output lldma_pkg::mem_out_t mem_out,
    input wire logic bus_gnt,
    input wire logic mem_ready,
    input wire logic [15:0] mem_rdata,
    output logic irq_req
);
    import lldma_pkg::*;

    chan_regs_t r, next_r;

    function automatic logic is_ready(input logic [7:0] ts);
        is_ready = (ts == `TS_READY) || (ts == `TS_READY_NOTIFY) ||
            (ts[7:6] == `TS_CMD_PLAIN) || (ts[7:6] == `TS_CMD_NOTIFY);
    endfunction

    function automatic logic [23:0] ent(input logic [20:0] p,
                                        input logic [2:0] off);
        ent = {p, off};
    endfunction

    // with the bus held, the client's lines pick the next step; no
    // request at all hands the bus back
    function automatic chan_state_t after_entry(input client_in_t c);
        if (c.data_req) begin
            after_entry = S_XFER;
        end else if (c.terminate) begin
            after_entry = S_WR_LEN;
        end else begin
            after_entry = S_IDLE;
        end
    endfunction

    logic bus_hit;
    logic acc_done;
    logic [7:0] ts_in;
    logic [7:0] mem_byte;
    logic wants;
    logic pend_set;
    logic buf_done_irq;
    logic [15:0] cnt_dec;
    logic [1:0] bsel;

    assign bus_hit = (avs_read || avs_write) && !r.ack;
    assign avs_waitrequest = (avs_read || avs_write) && !r.ack;
    assign avs_readdata = r.rdata;
    assign irq_req = r.ctrl[`CS_PEND];
    assign acc_done = bus_gnt && mem_ready;
    assign ts_in = mem_rdata[7:0];
    // byte lane follows the low address bit of a little-endian word bus
    assign mem_byte = r.buf_addr[0] ? mem_rdata[15:8] : mem_rdata[7:0];
    assign wants = client_in.data_req || client_in.terminate;
    assign cnt_dec = r.cnt - 16'h0001;
    assign bsel = r.ctrl[`CS_BSEL_HI:`CS_BSEL_LO];
    assign buf_done_irq = (bsel != `BSEL_NONE) &&
        ((bsel != `BSEL_NOTIFY) || r.notify);

    // memory and handshake outputs decode from state; rd and wr need bus_gnt and the handshake strobes scan_sel,
    // but word stays high outside S_XFER and rdata is driven in every state
    always_comb begin
        mem_out = '0;
        client_out = '0;
        client_out.rdata = r.cdata;
        client_out.type_fetch = r.tf && scan_sel; // RULE_06 RULE_22
        mem_out.bus_req = (r.st != S_IDLE);
        mem_out.word = 1'b1; // RULE_21
        case (r.st)
            S_REQ_BUS: begin
                mem_out.bus_req = 1'b1;
            end
            S_FETCH_TS: begin
                mem_out.addr = ent(r.list_ptr, `ENT_TYPE); // RULE_02
                mem_out.rd = bus_gnt;
            end
            S_WR_PROG: begin
                mem_out.addr = ent(r.list_ptr, `ENT_TYPE);
                mem_out.wr = bus_gnt;
                mem_out.wdata = {8'h00, `TS_IN_PROG}; // RULE_07
            end
            S_RD_A0: begin
                mem_out.addr = ent(r.list_ptr, `ENT_ADDR_LO);
                mem_out.rd = bus_gnt;
            end
            S_RD_A2: begin
                mem_out.addr = ent(r.list_ptr, `ENT_ADDR_HI);
                mem_out.rd = bus_gnt;
            end
            S_RD_LEN: begin
                mem_out.addr = ent(r.list_ptr, `ENT_LEN);
                mem_out.rd = bus_gnt;
            end
            S_XFER: begin
                mem_out.word = 1'b0; // RULE_21
                mem_out.addr = r.buf_addr; // RULE_09
                mem_out.rd = bus_gnt && !r.ctrl[`CS_DIR];
                mem_out.wr = bus_gnt && r.ctrl[`CS_DIR];
                mem_out.wdata = {client_in.wdata, client_in.wdata};
                // one acknowledge per byte, on the completing cycle
                client_out.data_ack = acc_done && scan_sel; // RULE_09
                client_out.end_of_buffer_line = acc_done && scan_sel &&
                    r.notify && (r.cnt == 16'h0001); // RULE_10
                if (!r.ctrl[`CS_DIR]) begin
                    client_out.rdata = mem_byte;
                end
            end
            S_WR_LEN: begin
                mem_out.addr = ent(r.list_ptr, `ENT_LEN);
                mem_out.wr = bus_gnt;
                mem_out.wdata = r.cnt; // RULE_16
            end
            S_WR_STAT: begin
                mem_out.addr = ent(r.list_ptr, `ENT_TYPE);
                mem_out.wr = bus_gnt;
                mem_out.wdata = {8'h00, `TS_DONE_STAT,
                    client_in.wdata[5:0]}; // RULE_17 RULE_18
                client_out.store_status = acc_done && scan_sel; // RULE_17
            end
            S_WR_DONE: begin
                mem_out.addr = ent(r.list_ptr, `ENT_TYPE);
                mem_out.wr = bus_gnt;
                mem_out.wdata = {8'h00, `TS_DONE}; // RULE_14
            end
            default: begin
                mem_out.bus_req = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_r = r;
        next_r.tf = 1'b0;
        next_r.ack = bus_hit;
        pend_set = 1'b0;
        case (r.st)
            S_IDLE: begin
                // the scanner grants lowest channel first; this channel
                // asks only while it holds the scan slot
                if (r.run && (wants || r.pend_fetch) &&
                    scan_sel) begin // RULE_08 RULE_24
                    next_r.st = S_REQ_BUS;
                end
            end
            S_REQ_BUS: begin
                if (bus_gnt) begin
                    if (r.pend_fetch) begin
                        next_r.st = S_FETCH_TS; // RULE_01
                    end else begin
                        next_r.st = after_entry(client_in); // RULE_08
                    end
                end
            end
            S_FETCH_TS: begin
                if (acc_done) begin
                    next_r.pend_fetch = 1'b0;
                    next_r.tf = 1'b1; // RULE_06
                    next_r.cdata = ts_in; // RULE_06
                    next_r.notify = (ts_in == `TS_READY_NOTIFY) ||
                        (ts_in[7:6] == `TS_CMD_NOTIFY); // RULE_03
                    if (ts_in == `TS_LINK) begin
                        next_r.link = 1'b1; // RULE_05
                        next_r.st = S_RD_A0; // RULE_05
                    end else if (is_ready(ts_in)) begin
                        next_r.st = S_WR_PROG; // RULE_07
                    end else begin
                        next_r.run = 1'b0; // RULE_04
                        pend_set = r.ctrl[`CS_LIST_IE]; // RULE_04
                        next_r.st = S_IDLE;
                    end
                end
            end
            S_WR_PROG: begin
                if (acc_done) begin
                    next_r.st = S_RD_A0;
                end
            end
            S_RD_A0: begin
                if (acc_done) begin
                    next_r.buf_addr[15:0] = mem_rdata;
                    next_r.st = S_RD_A2;
                end
            end
            S_RD_A2: begin
                if (acc_done) begin
                    next_r.buf_addr[23:16] = mem_rdata[7:0];
                    if (r.link) begin
                        // a link carries the next list base in its
                        // address field; the low three bits are dropped
                        next_r.list_ptr = {mem_rdata[7:0],
                            r.buf_addr[15:3]}; // RULE_05
                        next_r.link = 1'b0;
                        next_r.st = S_FETCH_TS; // RULE_05
                    end else begin
                        next_r.st = S_RD_LEN;
                    end
                end
            end
            S_RD_LEN: begin
                if (acc_done) begin
                    next_r.cnt = mem_rdata; // RULE_07
                    next_r.st = after_entry(client_in); // RULE_08
                end
            end
            S_XFER: begin
                if (acc_done) begin
                    next_r.buf_addr = r.buf_addr + 24'h000001; // RULE_12
                    next_r.cnt = cnt_dec; // RULE_12
                    if (client_in.terminate) begin
                        next_r.st = S_WR_LEN; // RULE_16
                    end else if (cnt_dec == 16'h0000) begin
                        next_r.st = S_WR_DONE; // RULE_14
                    end else if (r.ctrl[`CS_BURST] &&
                        client_in.data_req) begin
                        next_r.st = S_XFER; // RULE_13
                    end else begin
                        next_r.st = S_IDLE; // RULE_13
                    end
                end
            end
            S_WR_LEN: begin
                if (acc_done) begin
                    next_r.st = S_WR_STAT; // RULE_17
                end
            end
            S_WR_STAT: begin
                if (acc_done) begin
                    next_r.list_ptr = r.list_ptr + 21'h000001; // RULE_19
                    pend_set = (bsel != `BSEL_NONE); // RULE_19
                    next_r.st = S_FETCH_TS; // RULE_19
                end
            end
            S_WR_DONE: begin
                if (acc_done) begin
                    next_r.list_ptr = r.list_ptr + 21'h000001; // RULE_14
                    pend_set = buf_done_irq; // RULE_15
                    next_r.st = S_FETCH_TS; // RULE_14
                end
            end
            default: begin
                next_r.st = S_IDLE;
            end
        endcase

        // read data is latched in the first cycle of an access so it
        // already stands when waitrequest drops
        if (bus_hit && avs_read) begin
            case (avs_address)
                `OFF_LIST_PTR: begin // RULE_23
                    next_r.rdata = {8'h00, r.list_ptr, `ENT_TYPE};
                end
                `OFF_CTRL_STAT: begin
                    next_r.rdata = {24'h000000, r.run, r.ctrl[6:0]};
                end
                `OFF_BUF_ADDR: begin
                    next_r.rdata = {8'h00, r.buf_addr};
                end
                `OFF_REM_COUNT: begin
                    next_r.rdata = {16'h0000, r.cnt};
                end
                default: begin
                    next_r.rdata = 32'h00000000;
                end
            endcase
        end

        // writes land once, in the cycle waitrequest is low
        if (avs_write && r.ack) begin
            case (avs_address)
                `OFF_LIST_PTR: begin
                    if (avs_byteenable[0]) begin // RULE_23
                        next_r.list_ptr[4:0] = avs_writedata[7:3];
                    end
                    if (avs_byteenable[1]) begin
                        next_r.list_ptr[12:5] = avs_writedata[15:8];
                    end
                    if (avs_byteenable[2]) begin
                        next_r.list_ptr[20:13] = avs_writedata[23:16];
                        next_r.run = 1'b1; // RULE_01
                        next_r.pend_fetch = 1'b1; // RULE_01
                    end
                end
                `OFF_CTRL_STAT: begin
                    if (avs_byteenable[0]) begin
                        next_r.ctrl[4:0] = avs_writedata[4:0];
                        // pending is write-one-to-clear
                        if (avs_writedata[`CS_PEND]) begin
                            next_r.ctrl[`CS_PEND] = 1'b0;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // a completion in the same cycle as a clear keeps the flag set
        if (pend_set) begin
            next_r.ctrl[`CS_PEND] = 1'b1; // RULE_15
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // checks on the channel's own decisions, all on clk
    sequence ptr_armed_s;
        avs_write && !avs_waitrequest && (avs_address == `OFF_LIST_PTR) &&
            avs_byteenable[2];
    endsequence
    sequence byte_moved_s;
        (r.st == S_XFER) && acc_done;
    endsequence
    sequence len_saved_s;
        (r.st == S_WR_LEN) && acc_done;
    endsequence
    sequence last_byte_s;
        (r.st == S_XFER) && acc_done && !client_in.terminate &&
            (r.cnt == 16'h0001);
    endsequence

    start_run_a: assert property (@(posedge clk) disable iff (rst) // RULE_01
        ptr_armed_s |=> (r.run && r.pend_fetch))
        else $error("pointer write did not start the channel");
    stop_code_a: assert property (@(posedge clk) disable iff (rst) // RULE_04
        ((r.st == S_FETCH_TS) && acc_done && !is_ready(ts_in) &&
            (ts_in != `TS_LINK) && !avs_write) |=> !r.run)
        else $error("stop code left the channel running");
    link_follow_a: assert property (@(posedge clk) disable iff (rst) // RULE_05
        ((r.st == S_RD_A2) && acc_done && r.link) |=> (r.st == S_FETCH_TS))
        else $error("link entry not followed");
    type_pulse_a: assert property (@(posedge clk) disable iff (rst) // RULE_06
        client_out.type_fetch |=> !client_out.type_fetch)
        else $error("type fetch longer than one cycle");
    eob_last_a: assert property (@(posedge clk) disable iff (rst) // RULE_10
        client_out.end_of_buffer_line |-> (client_out.data_ack &&
            r.notify && (r.cnt == 16'h0001)))
        else $error("end of buffer outside the last notify byte");
    step_count_a: assert property (@(posedge clk) disable iff (rst) // RULE_12
        byte_moved_s |=> ((r.buf_addr == $past(r.buf_addr) + 24'h000001) &&
            (r.cnt == $past(r.cnt) - 16'h0001)))
        else $error("address or count not stepped");
    done_write_a: assert property (@(posedge clk) disable iff (rst) // RULE_14
        last_byte_s |=> ((r.st == S_WR_DONE) &&
            (mem_out.wdata == {8'h00, `TS_DONE})))
        else $error("finished buffer not marked done");
    term_order_a: assert property (@(posedge clk) disable iff (rst) // RULE_17
        len_saved_s |=> (r.st == S_WR_STAT))
        else $error("status write did not follow length save");
    stat_code_a: assert property (@(posedge clk) disable iff (rst) // RULE_17
        client_out.store_status |-> (mem_out.wr &&
            (mem_out.wdata[7:6] == `TS_DONE_STAT)))
        else $error("store status without status write");
    list_width_a: assert property (@(posedge clk) disable iff (rst) // RULE_21
        (mem_out.rd || mem_out.wr) |-> (mem_out.word == (r.st != S_XFER)))
        else $error("wrong access width");
endmodule
`default_nettype wire

// ==== shared/lldma_defines.svh ====
`ifndef LLDMA_DEFINES_SVH
`define LLDMA_DEFINES_SVH

// register byte offsets on the Avalon slave
`define OFF_LIST_PTR 4'h0
`define OFF_CTRL_STAT 4'h4
`define OFF_BUF_ADDR 4'h8
`define OFF_REM_COUNT 4'hC

// channel_ctrl_stat_reg fields
`define CS_DIR 0
`define CS_BURST 1
`define CS_LIST_IE 2
`define CS_BSEL_LO 3
`define CS_BSEL_HI 4
`define CS_PEND 6
`define CS_RUN 7
`define CS_RESET 8'h00

// byte offsets inside a list entry
`define ENT_ADDR_LO 3'h0
`define ENT_ADDR_HI 3'h2
`define ENT_TYPE 3'h4
`define ENT_LEN 3'h6

// type/status codes
`define TS_END 8'h00
`define TS_LINK 8'h01
`define TS_READY 8'h02
`define TS_READY_NOTIFY 8'h03
`define TS_IN_PROG 8'h04
`define TS_DONE 8'h05
`define TS_CMD_PLAIN 2'h1
`define TS_CMD_NOTIFY 2'h2
`define TS_DONE_STAT 2'h3

// buffer_irq_select encodings
`define BSEL_NONE 2'h0
`define BSEL_NOTIFY 2'h1

`endif

// ==== shared/lldma_pkg.sv ====
package lldma_pkg;
    typedef enum logic [3:0] {
        S_IDLE, S_REQ_BUS, S_FETCH_TS, S_WR_PROG, S_RD_A0, S_RD_A2,
        S_RD_LEN, S_XFER, S_WR_LEN, S_WR_STAT, S_WR_DONE
    } chan_state_t;

    typedef struct packed {
        logic data_req;
        logic terminate;
        logic [7:0] wdata;
    } client_in_t;

    typedef struct packed {
        logic type_fetch;
        logic data_ack;
        logic end_of_buffer_line;
        logic store_status;
        logic [7:0] rdata;
    } client_out_t;

    typedef struct packed {
        logic bus_req;
        logic [23:0] addr;
        logic rd;
        logic wr;
        logic word;
        logic [15:0] wdata;
    } mem_out_t;

    typedef struct packed {
        chan_state_t st;
        logic run;
        logic pend_fetch;
        logic [20:0] list_ptr;
        logic [23:0] buf_addr;
        logic [15:0] cnt;
        logic notify;
        logic link;
        logic [7:0] ctrl;
        logic tf;
        logic [7:0] cdata;
        logic ack;
        logic [31:0] rdata;
    } chan_regs_t;
endpackage
